//--- core/adc_select_pkg.sv
// constants and types shared by the channel-select and result block
package adc_select_pkg;
   // bus geometry: each register index sits at byte address index*4
   localparam int unsigned ADDR_WIDTH = 12;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned IDX_WIDTH  = 9;

   // register indices
   localparam logic [8:0] IDX_CONTROL  = 9'h02E;
   localparam logic [8:0] IDX_SKIP_A   = 9'h02F;
   localparam logic [8:0] IDX_SKIP_B   = 9'h030;
   localparam logic [8:0] IDX_IN_CUR   = 9'h031;
   localparam logic [8:0] IDX_BAT_CUR  = 9'h033;
   localparam logic [8:0] IDX_IN_VOLT  = 9'h035;
   localparam logic [8:0] IDX_COMMAND  = 9'h050;

   // field positions
   localparam int unsigned CTRL_ENABLE_BIT = 7;
   localparam int unsigned CTRL_RATE_BIT   = 6;
   localparam int unsigned CMD_RESET_BIT   = 0;
   localparam int unsigned CMD_BUSY_BIT    = 1;

   // writable bits of each register
   localparam logic [7:0] SKIP_A_MASK = 8'hFE;
   localparam logic [7:0] SKIP_B_MASK = 8'hF0;
   localparam logic [7:0] CTRL_MASK   = 8'hC0;

   // values after reset
   localparam logic [7:0]  SKIP_RESET   = 8'h00;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // conversion sequence: channel numbers in scan order
   localparam int unsigned CHAN_WIDTH  = 4;
   localparam int unsigned CHAN_COUNT  = 11;
   localparam logic [3:0]  CH_IN_CUR   = 4'h0;
   localparam logic [3:0]  CH_BAT_CUR  = 4'h1;
   localparam logic [3:0]  CH_IN_VOLT  = 4'h2;
   localparam logic [3:0]  CH_LAST     = 4'hA;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT} seq_state_type;
endpackage : adc_select_pkg

//--- core/result_hold.sv
// one signed result register loaded from a magnitude and a direction
`timescale 1ns/10ps
module result_hold (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [14:0] magnitude,
   input  wire logic        negative,
   output logic      [15:0] value
);
   logic [15:0] widened;
   logic [15:0] signed_value;

   // reverse flow reports as the two's complement of the magnitude
   assign widened      = {1'b0, magnitude};
   assign signed_value = negative ? 16'(-widened) : widened;

   // whole word replaced at once, so both bytes stay from one sample
   always_ff @(posedge clk) begin
      if (rst) begin
         value <= adc_select_pkg::RESULT_RESET;
      end else if (load) begin
         value <= signed_value;
      end
   end
endmodule : result_hold

//--- core/adc_channel_select.sv
// converter channel selection, sequencing and result registers
//
// Summary of operation
// RULE_01: first skip register drops seven channels
// RULE_02: second skip register drops four channels
// RULE_03: set bit skips channel; resets clear all
// RULE_04: input current result, signed, 1 mA steps
// RULE_05: input current negative for reverse flow
// RULE_06: battery current result, signed, 1 mA steps
// RULE_07: battery current positive charging, negative discharging
// RULE_08: input voltage result, signed, 1 mV steps
// RULE_09: convert only when enabled; one-shot or continuous
// RULE_10: result halves always from one conversion
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module adc_channel_select (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [11:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [11:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   output logic             CONV_START,
   output logic [3:0]       CONV_CHANNEL,
   input  wire logic        CONV_DONE,
   input  wire logic [14:0] CONV_MAGNITUDE,
   input  wire logic        CONV_NEGATIVE
);
   logic                      aw_held;
   logic                      w_held;
   logic [8:0]                aw_idx;
   logic [7:0]                w_byte;
   logic                      w_lane;
   logic                      wr_fire;
   logic                      wr_hit;
   logic                      wr_ctrl;
   logic                      wr_skip_a;
   logic                      wr_skip_b;
   logic                      cmd_reset;
   logic [8:0]                ar_idx;
   logic                      ar_take;
   logic                      rd_hit;
   logic [31:0]               read_word;
   logic [8:0]                rd_idx;
   logic [7:0]                ctrl;
   logic [7:0]                skip_a;
   logic [7:0]                skip_b;
   logic [10:0]               chan_skip;
   logic                      enable;
   logic                      one_shot;
   logic                      busy;
   adc_select_pkg::seq_state_type state;
   adc_select_pkg::seq_state_type next_state;
   logic [3:0]                chan;
   logic [3:0]                next_chan;
   logic                      step;
   logic                      pass_end;
   logic                      oneshot_end;
   logic                      load_in_cur;
   logic                      load_bat_cur;
   logic                      load_in_volt;
   logic [15:0]               in_cur;
   logic [15:0]               bat_cur;
   logic [15:0]               in_volt;

   // write channel acceptance: address and data taken in either order
   assign AWREADY   = !aw_held && !BVALID;
   assign WREADY    = !w_held && !BVALID;
   assign wr_fire   = aw_held && w_held;
   assign wr_hit    = (aw_idx == adc_select_pkg::IDX_CONTROL)
                   || (aw_idx == adc_select_pkg::IDX_SKIP_A)
                   || (aw_idx == adc_select_pkg::IDX_SKIP_B)
                   || (aw_idx == adc_select_pkg::IDX_IN_CUR)
                   || (aw_idx == adc_select_pkg::IDX_BAT_CUR)
                   || (aw_idx == adc_select_pkg::IDX_IN_VOLT)
                   || (aw_idx == adc_select_pkg::IDX_COMMAND);
   assign wr_ctrl   = wr_fire && w_lane
                   && (aw_idx == adc_select_pkg::IDX_CONTROL);
   assign wr_skip_a = wr_fire && w_lane
                   && (aw_idx == adc_select_pkg::IDX_SKIP_A);
   assign wr_skip_b = wr_fire && w_lane
                   && (aw_idx == adc_select_pkg::IDX_SKIP_B);
   assign cmd_reset = wr_fire && w_lane
                   && (aw_idx == adc_select_pkg::IDX_COMMAND)
                   && w_byte[adc_select_pkg::CMD_RESET_BIT];

   // hold address and data until both present, then answer
   always_ff @(posedge CLK) begin
      if (RST) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_idx  <= 9'h000;
         w_byte  <= 8'h00;
         w_lane  <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= adc_select_pkg::RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_held <= 1'b1;
            aw_idx  <= AWADDR[10:2];
         end
         if (WVALID && WREADY) begin
            w_held <= 1'b1;
            w_byte <= WDATA[7:0];
            w_lane <= WSTRB[0];
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            BVALID  <= 1'b1;
            BRESP   <= wr_hit ? adc_select_pkg::RESP_OKAY
                              : adc_select_pkg::RESP_SLVERR;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // converter control: software write wins over the one-shot clear
   always_ff @(posedge CLK) begin
      if (RST || cmd_reset) begin
         ctrl <= adc_select_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= w_byte & adc_select_pkg::CTRL_MASK;
      end else if (oneshot_end) begin
         ctrl[adc_select_pkg::CTRL_ENABLE_BIT] <= 1'b0; // [RULE_09]
      end
   end

   // skip registers; reserved bits never store a one
   always_ff @(posedge CLK) begin
      if (RST || cmd_reset) begin
         skip_a <= adc_select_pkg::SKIP_RESET; // [RULE_03]
         skip_b <= adc_select_pkg::SKIP_RESET; // [RULE_03]
      end else begin
         if (wr_skip_a) begin
            skip_a <= w_byte & adc_select_pkg::SKIP_A_MASK; // [RULE_01]
         end
         if (wr_skip_b) begin
            skip_b <= w_byte & adc_select_pkg::SKIP_B_MASK; // [RULE_02]
         end
      end
   end

   // read decode; results are 16-bit words returned in one beat
   assign ARREADY = !RVALID;
   assign ar_take = ARVALID && ARREADY;
   assign ar_idx  = ARADDR[10:2];
   assign busy    = (state != adc_select_pkg::SEQ_IDLE);
   always_comb begin
      read_word = 32'h00000000;
      rd_hit    = 1'b1;
      case (ar_idx)
         adc_select_pkg::IDX_CONTROL:  read_word[7:0] = ctrl;
         adc_select_pkg::IDX_SKIP_A:   read_word[7:0] = skip_a;
         adc_select_pkg::IDX_SKIP_B:   read_word[7:0] = skip_b;
         adc_select_pkg::IDX_IN_CUR:   read_word[15:0] = in_cur; // [RULE_10]
         adc_select_pkg::IDX_BAT_CUR:  read_word[15:0] = bat_cur;
         adc_select_pkg::IDX_IN_VOLT:  read_word[15:0] = in_volt;
         adc_select_pkg::IDX_COMMAND:
            read_word[adc_select_pkg::CMD_BUSY_BIT] = busy;
         default:                      rd_hit = 1'b0;
      endcase
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge CLK) begin
      if (RST) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h00000000;
         RRESP  <= adc_select_pkg::RESP_OKAY;
         rd_idx <= 9'h000;
      end else if (ar_take) begin
         RVALID <= 1'b1;
         RDATA  <= read_word;
         RRESP  <= rd_hit ? adc_select_pkg::RESP_OKAY
                          : adc_select_pkg::RESP_SLVERR;
         rd_idx <= ar_idx;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // channel skip vector in scan order, input current first
   assign chan_skip = {skip_b[4], skip_b[5], skip_b[6], skip_b[7],
                       skip_a[1], skip_a[2], skip_a[3], skip_a[4],
                       skip_a[5], skip_a[6], skip_a[7]};
   assign enable    = ctrl[adc_select_pkg::CTRL_ENABLE_BIT];
   assign one_shot  = ctrl[adc_select_pkg::CTRL_RATE_BIT];

   // sequencer step: a skipped channel passes, a started one completes
   assign CONV_START = (state == adc_select_pkg::SEQ_SCAN) && enable
                    && !chan_skip[chan]; // [RULE_03] [RULE_09]
   assign step = ((state == adc_select_pkg::SEQ_SCAN) && enable
                  && chan_skip[chan])
              || ((state == adc_select_pkg::SEQ_WAIT) && CONV_DONE);
   assign pass_end    = step && (chan == adc_select_pkg::CH_LAST);
   assign oneshot_end = pass_end && one_shot; // [RULE_09]
   assign CONV_CHANNEL = chan;

   // next state of the conversion sequence
   always_comb begin
      next_state = state;
      next_chan  = chan;
      case (state)
         adc_select_pkg::SEQ_IDLE: begin
            next_chan = adc_select_pkg::CH_IN_CUR;
            if (enable) begin
               next_state = adc_select_pkg::SEQ_SCAN; // [RULE_09]
            end
         end
         adc_select_pkg::SEQ_SCAN: begin
            if (!enable) begin
               next_state = adc_select_pkg::SEQ_IDLE;
            end else if (CONV_START) begin
               next_state = adc_select_pkg::SEQ_WAIT;
            end
         end
         adc_select_pkg::SEQ_WAIT: begin
            if (CONV_DONE) begin
               next_state = adc_select_pkg::SEQ_SCAN;
            end
         end
         default: next_state = adc_select_pkg::SEQ_IDLE;
      endcase
      if (pass_end) begin
         next_chan  = adc_select_pkg::CH_IN_CUR;
         next_state = one_shot ? adc_select_pkg::SEQ_IDLE
                               : adc_select_pkg::SEQ_SCAN; // [RULE_09]
      end else if (step) begin
         next_chan = chan + 4'h1;
      end
   end

   // sequencer registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= adc_select_pkg::SEQ_IDLE;
         chan  <= adc_select_pkg::CH_IN_CUR;
      end else begin
         state <= next_state;
         chan  <= next_chan;
      end
   end

   // result loads on completion of the matching channel
   assign load_in_cur  = (state == adc_select_pkg::SEQ_WAIT) && CONV_DONE
                      && (chan == adc_select_pkg::CH_IN_CUR);
   assign load_bat_cur = (state == adc_select_pkg::SEQ_WAIT) && CONV_DONE
                      && (chan == adc_select_pkg::CH_BAT_CUR);
   assign load_in_volt = (state == adc_select_pkg::SEQ_WAIT) && CONV_DONE
                      && (chan == adc_select_pkg::CH_IN_VOLT);

   // input current: positive from input pin toward the middle node
   result_hold in_cur_hold (
      .clk       (CLK),
      .rst       (RST),
      .load      (load_in_cur), // [RULE_04] [RULE_05]
      .magnitude (CONV_MAGNITUDE),
      .negative  (CONV_NEGATIVE),
      .value     (in_cur)
   );

   // battery current: positive while charging
   result_hold bat_cur_hold (
      .clk       (CLK),
      .rst       (RST),
      .load      (load_bat_cur), // [RULE_06] [RULE_07]
      .magnitude (CONV_MAGNITUDE),
      .negative  (CONV_NEGATIVE),
      .value     (bat_cur)
   );

   // input voltage
   result_hold in_volt_hold (
      .clk       (CLK),
      .rst       (RST),
      .load      (load_in_volt), // [RULE_08]
      .magnitude (CONV_MAGNITUDE),
      .negative  (CONV_NEGATIVE),
      .value     (in_volt)
   );

   // checks on the logic above
   property p_skip_a_reserved;
      @(posedge CLK) disable iff (RST)
      RVALID && (rd_idx == adc_select_pkg::IDX_SKIP_A) |-> RDATA[0] == 1'b0;
   endproperty
   a_skip_a_reserved: assert property (p_skip_a_reserved) // [RULE_01]
      else $error("reserved skip bit read as one");

   property p_skip_b_reserved;
      @(posedge CLK) disable iff (RST)
      RVALID && (rd_idx == adc_select_pkg::IDX_SKIP_B)
         |-> RDATA[3:0] == 4'h0;
   endproperty
   a_skip_b_reserved: assert property (p_skip_b_reserved) // [RULE_02]
      else $error("reserved second skip bits read as one");

   property p_reset_clears_skip;
      @(posedge CLK) disable iff (RST)
      cmd_reset |=> (skip_a == 8'h00) && (skip_b == 8'h00) && !enable;
   endproperty
   a_reset_clears_skip: assert property (p_reset_clears_skip) // [RULE_03]
      else $error("register reset left a skip bit set");

   property p_no_skipped_start;
      @(posedge CLK) disable iff (RST)
      CONV_START |-> !chan_skip[CONV_CHANNEL];
   endproperty
   a_no_skipped_start: assert property (p_no_skipped_start) // [RULE_03]
      else $error("skipped channel was started");

   property p_in_cur_only_on_load;
      @(posedge CLK) disable iff (RST)
      !load_in_cur |=> $stable(in_cur);
   endproperty
   a_in_cur_only_on_load: assert property (p_in_cur_only_on_load) // [RULE_04]
      else $error("input current changed without a conversion");

   property p_in_cur_sign;
      @(posedge CLK) disable iff (RST)
      load_in_cur |=> in_cur == ($past(CONV_NEGATIVE)
         ? 16'(-{1'b0, $past(CONV_MAGNITUDE)})
         : {1'b0, $past(CONV_MAGNITUDE)});
   endproperty
   a_in_cur_sign: assert property (p_in_cur_sign) // [RULE_05]
      else $error("input current sign or value wrong");

   property p_bat_cur_sign;
      @(posedge CLK) disable iff (RST)
      load_bat_cur ##1 $past(CONV_NEGATIVE) && ($past(CONV_MAGNITUDE) != 0)
         |-> bat_cur[15] && $stable(in_cur);
   endproperty
   a_bat_cur_sign: assert property (p_bat_cur_sign) // [RULE_06] [RULE_07]
      else $error("discharging battery current not negative");

   property p_in_volt_value;
      @(posedge CLK) disable iff (RST)
      load_in_volt && !CONV_NEGATIVE
         |=> in_volt == {1'b0, $past(CONV_MAGNITUDE)};
   endproperty
   a_in_volt_value: assert property (p_in_volt_value) // [RULE_08]
      else $error("input voltage result wrong");

   property p_idle_when_disabled;
      @(posedge CLK) disable iff (RST)
      !enable && (state != adc_select_pkg::SEQ_WAIT) |=> !CONV_START;
   endproperty
   a_idle_when_disabled: assert property (p_idle_when_disabled) // [RULE_09]
      else $error("conversion started while disabled");

   property p_one_shot_stops;
      @(posedge CLK) disable iff (RST)
      oneshot_end && !wr_ctrl |=> !enable ##1 !CONV_START;
   endproperty
   a_one_shot_stops: assert property (p_one_shot_stops) // [RULE_09]
      else $error("one-shot pass did not stop");

   property p_read_stable;
      @(posedge CLK) disable iff (RST)
      RVALID && !RREADY |=> RVALID && $stable(RDATA);
   endproperty
   a_read_stable: assert property (p_read_stable) // [RULE_10]
      else $error("read data changed before taken");
endmodule : adc_channel_select

//--- dv/adc_channel_select_and_results_tb.sv
// self-checking bench for the channel-select and result registers
`timescale 1ns/10ps
module adc_channel_select_and_results_tb;
   // byte addresses: register index times four
   localparam logic [11:0] A_CTL  = {1'b0, adc_select_pkg::IDX_CONTROL, 2'b00};
   localparam logic [11:0] A_SKA  = {1'b0, adc_select_pkg::IDX_SKIP_A, 2'b00};
   localparam logic [11:0] A_SKB  = {1'b0, adc_select_pkg::IDX_SKIP_B, 2'b00};
   localparam logic [11:0] A_INC  = {1'b0, adc_select_pkg::IDX_IN_CUR, 2'b00};
   localparam logic [11:0] A_BATC = {1'b0, adc_select_pkg::IDX_BAT_CUR, 2'b00};
   localparam logic [11:0] A_INV  = {1'b0, adc_select_pkg::IDX_IN_VOLT, 2'b00};
   localparam logic [11:0] A_CMD  = {1'b0, adc_select_pkg::IDX_COMMAND, 2'b00};

   typedef struct {
      logic [11:0] a;
      logic        wr;
      logic [7:0]  d;
      logic [31:0] rd;
      logic [1:0]  rr;
      logic [1:0]  br;
   } row_type;

   logic        CLK, RST;
   logic [11:0] AWADDR, ARADDR;
   logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic [31:0] WDATA, RDATA;
   logic [3:0]  WSTRB, CONV_CHANNEL;
   logic [1:0]  BRESP, RRESP;
   logic        ARVALID, ARREADY, RVALID, RREADY;
   logic        CONV_START, CONV_DONE, CONV_NEGATIVE;
   logic [14:0] CONV_MAGNITUDE;
   logic [14:0] mag_tab [0:10];
   logic [10:0] neg_tab, seen_mask;
   logic [3:0]  active_ch;
   logic        pend;
   int          wait_left, conv_wait, start_count, num_errors, n_compared;
   row_type     rows [0:9];

   adc_channel_select DUT (
      .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
      .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL),
      .CONV_DONE(CONV_DONE), .CONV_MAGNITUDE(CONV_MAGNITUDE),
      .CONV_NEGATIVE(CONV_NEGATIVE)
   );

   // 125 MHz clock
   always #4 CLK = ~CLK;

   // converter stand-in: answers each start after conv_wait idle cycles
   always @(posedge CLK) begin
      CONV_DONE <= 1'b0;
      if (CONV_START) begin
         seen_mask[CONV_CHANNEL] <= 1'b1;
         start_count <= start_count + 1;
         wait_left <= conv_wait;
         active_ch <= CONV_CHANNEL;
         pend <= 1'b1;
      end else if (pend && wait_left == 0) begin
         CONV_DONE <= 1'b1;
         CONV_MAGNITUDE <= mag_tab[active_ch];
         CONV_NEGATIVE <= neg_tab[active_ch];
         pend <= 1'b0;
      end else begin
         wait_left <= wait_left - 1;
         CONV_MAGNITUDE <= ~CONV_MAGNITUDE; // no stale value between answers
      end
   end

   // compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one bus write; response returned in r
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                            output logic [1:0] r);
      int  n;
      logic done;
      n = 0;
      done = 1'b0;
      r = 2'h3;
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= {24'h000000, d};
      WSTRB <= 4'hF;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!done && n < 100) begin
         @(posedge CLK);
         n++;
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
         if (BVALID && BREADY) begin
            r = BRESP;
            done = 1'b1;
         end
      end
      if (!done) check(32'h0, 32'h1);
   endtask : axi_write

   // one bus read; data and response returned
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      int  n;
      logic done;
      n = 0;
      done = 1'b0;
      d = 32'hFFFFFFFF;
      r = 2'h3;
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!done && n < 100) begin
         @(posedge CLK);
         n++;
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
         if (RVALID && RREADY) begin
            d = RDATA;
            r = RRESP;
            done = 1'b1;
         end
      end
      if (!done) check(32'h0, 32'h2);
   endtask : axi_read

   // poll the busy flag until the sequencer is idle
   task automatic wait_idle;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      n = 0;
      d = 32'h2;
      while (d[adc_select_pkg::CMD_BUSY_BIT] !== 1'b0 && n < 300) begin
         axi_read(A_CMD, d, r);
         n++;
      end
      if (n >= 300) check(32'h0, 32'h3);
   endtask : wait_idle

   // verdict and end of run
   task automatic test_done;
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge CLK);
      num_errors++;
      test_done;
   end

   // main sequence
   initial begin : main
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      CLK = 1'b0; RST = 1'b1; AWADDR = 12'h000; AWVALID = 1'b0;
      WDATA = 32'h0; WSTRB = 4'h0; WVALID = 1'b0; BREADY = 1'b0;
      ARADDR = 12'h000; ARVALID = 1'b0; RREADY = 1'b0; CONV_DONE = 1'b0;
      CONV_MAGNITUDE = 15'h0000; CONV_NEGATIVE = 1'b0; pend = 1'b0;
      wait_left = 0; conv_wait = 0; start_count = 0; active_ch = 4'h0;
      seen_mask = 11'h000; num_errors = 0; n_compared = 0;
      mag_tab = '{15'h04D2, 15'h01F4, 15'h7530, 15'h0011, 15'h0022,
                  15'h0033, 15'h0044, 15'h0055, 15'h0066, 15'h0077, 15'h0088};
      neg_tab = 11'h002;
      // reset values, masks of reserved bits, read-only and unmapped places
      rows = '{'{A_SKA, 0, 8'h00, 32'h0, 2'h0, 2'h0},
               '{A_SKB, 0, 8'h00, 32'h0, 2'h0, 2'h0},
               '{A_INC, 0, 8'h00, 32'h0, 2'h0, 2'h0},
               '{A_BATC, 0, 8'h00, 32'h0, 2'h0, 2'h0},
               '{A_INV, 0, 8'h00, 32'h0, 2'h0, 2'h0},
               '{A_CTL, 0, 8'h00, 32'h0, 2'h0, 2'h0},
               '{A_SKA, 1, 8'hFF, 32'hFE, 2'h0, 2'h0},
               '{A_SKB, 1, 8'hFF, 32'hF0, 2'h0, 2'h0},
               '{A_INC, 1, 8'hFF, 32'h0, 2'h0, 2'h0},
               '{12'h100, 1, 8'hFF, 32'h0, 2'h2, 2'h2}};
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            axi_write(rows[i].a, rows[i].d, r);
            check({30'h0, r}, {30'h0, rows[i].br});
         end
         axi_read(rows[i].a, d, r);
         check(d, rows[i].rd);
         check({30'h0, r}, {30'h0, rows[i].rr});
      end
      // register-reset command clears both skip registers
      axi_write(A_CMD, 8'h01, r);
      axi_read(A_SKA, d, r);
      check(d, 32'h0);
      axi_read(A_SKB, d, r);
      check(d, 32'h0);
      // one-shot pass, prompt converter, three channels skipped
      axi_write(A_SKA, 8'h50, r);
      axi_write(A_SKB, 8'h80, r);
      seen_mask <= 11'h000;
      start_count <= 0;
      axi_write(A_CTL, 8'hC0, r);
      wait_idle;
      check({21'h0, seen_mask}, 32'h775);
      check(start_count, 32'd8);
      axi_read(A_INC, d, r);
      check(d, 32'h04D2);
      axi_read(A_BATC, d, r);
      check(d, 32'h0);
      axi_read(A_INV, d, r);
      check(d, 32'h7530);
      axi_read(A_CTL, d, r);
      check(d, 32'h40);
      // converter disabled: no requests at all
      start_count <= 0;
      repeat (30) @(posedge CLK);
      check(start_count, 32'd0);
      // continuous scan, slow converter, reverse flow and charging
      mag_tab[0] = 15'h1388;
      mag_tab[1] = 15'h1F40;
      neg_tab = 11'h001;
      conv_wait = 4;
      axi_write(A_SKA, 8'h00, r);
      axi_write(A_SKB, 8'h00, r);
      axi_write(A_CTL, 8'h80, r);
      n = 0;
      while (start_count < 25 && n < 200) begin
         axi_read(A_INC, d, r);
         check(d === 32'h04D2 || d === 32'hEC78, 1'b1);
         n++;
      end
      check(start_count >= 25, 1'b1);
      axi_write(A_CTL, 8'h00, r);
      wait_idle;
      axi_read(A_INC, d, r);
      check(d, 32'hEC78);
      axi_read(A_BATC, d, r);
      check(d, 32'h1F40);
      axi_read(A_INV, d, r);
      check(d, 32'h7530);
      // one-shot pass with the battery discharging
      neg_tab = 11'h002;
      axi_write(A_CTL, 8'hC0, r);
      wait_idle;
      axi_read(A_BATC, d, r);
      check(d, 32'hE0C0);
      axi_read(A_INC, d, r);
      check(d, 32'h1388);
      // read answer stands while the master holds off
      RREADY <= 1'b0;
      ARADDR <= A_INV;
      ARVALID <= 1'b1;
      @(posedge CLK);
      ARVALID <= 1'b0;
      repeat (3) @(posedge CLK);
      check({31'h0, RVALID}, 32'h1);
      RREADY <= 1'b1;
      @(posedge CLK);
      check(RDATA, 32'h7530);
      // reset in mid-run returns registers and results to zero
      axi_write(A_SKA, 8'hFE, r);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      axi_read(A_SKA, d, r);
      check(d, 32'h0);
      axi_read(A_BATC, d, r);
      check(d, 32'h0);
      test_done;
   end
endmodule : adc_channel_select_and_results_tb
